//--- verilog/spch_handler.sv
// Serial packet command handler: UART, packet check, reply, command actions
`default_nettype none
// Contract
// - Link runs 9600 baud, eight data bits, no parity, one stop bit.
// - Half duplex: device transmits only after a full command packet.
// - RTS active wakes device; RTS drop ends the received packet.
// - Packet: preamble AA, length, command, data, two CRC bytes.
// - Reply command byte equals the received command code.
// - 16-bit CRC at packet end, low byte first.
// - Malformed command gets fixed reply AA 05 FF A1 CB.
// - Reply first, then carry out the command action.
// - Command 00 carries 1..144 payload bytes, acknowledged AA 05 00 D9 C4; code passes only the first FIFO_DEPTH bytes to pay_data_o.
// - Command 01 returns length 09 with four-byte serial number.
// - Command 03 aborts transmission, echoes AA 05 03 42 F6.
// - Command 04 returns length 06 with bursts remaining.
// - Command 05 returns length 07 with major, minor firmware version.
// - Command 06 length 0E sets channel, bursts, intervals; kept persistently.
// - Channel values 0..3 select channels A..D.
// - Bursts per message range 01..14.
// - Minimum interval in five-second steps, range 01..3C.
// - Maximum interval in five-second steps, range 02..78.
// - Sleep only with no pending transmission and no serial activity.
module spch_handler
  import spch_pkg::*;
#(
  parameter logic [31:0] UNIT_SERIAL = 32'h0000_0001, // Arbitrary value
  parameter logic [7:0]  FW_MAJOR    = 8'h01,         // Arbitrary value
  parameter logic [7:0]  FW_MINOR    = 8'h00,         // Arbitrary value
  parameter int          BIT_CYCLES  = BIT_CYC,
  parameter int          FIFO_DEPTH  = 16
) (
  input  wire logic       core_clk_i,
  input  wire logic       srst_i,
  input  wire logic       rx_i,
  input  wire logic       rts_n_i,
  output logic            tx_o,
  output logic            awake_o,
  output logic            sleep_o,
  output logic [7:0]      pay_data_o,
  output logic            pay_valid_o,
  input  wire logic       pay_ready_i,
  output logic            send_start_o,
  output logic            abort_o,
  input  wire logic       tx_busy_i,
  input  wire logic [7:0] bursts_left_i,
  output logic [1:0]      rf_channel_o,
  output logic [7:0]      burst_count_o,
  output logic [7:0]      interval_min_o,
  output logic [7:0]      interval_max_o,
  output logic            setup_store_o
);
  import spch_pkg::*;
  initial begin
    if (FIFO_DEPTH < 16 || BIT_CYCLES < 8 || BIT_CYCLES > 65535) $error("spch_handler: bad FIFO_DEPTH or BIT_CYCLES");
  end

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [1:0] rx_sync;
  logic [1:0] rts_sync;
  logic       rts_act;
  logic       rts_act_d;
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      rx_sync  <= 2'h3;
      rts_sync <= 2'h3;
      rts_act_d <= 1'b0;
    end else begin
      rx_sync  <= {rx_sync[0], rx_i};
      rts_sync <= {rts_sync[0], rts_n_i};
      rts_act_d <= rts_act;
    end
  end
  assign rts_act = ~rts_sync[1];
  wire rts_fall = rts_act_d & ~rts_act;

  // ---------------------------------------------------------------
  // Receiver, 8N1
  // ---------------------------------------------------------------
  logic [15:0] rx_cnt;
  logic [3:0]  rx_bit;
  logic [7:0]  rx_sh;
  logic        rx_busy;
  logic        rx_stb;
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      rx_cnt <= '0; rx_bit <= '0; rx_sh <= '0; rx_busy <= 1'b0; rx_stb <= 1'b0;
    end else begin
      rx_stb <= 1'b0;
      if (!rx_busy) begin
        if (!rx_sync[1] && rts_act) begin
          rx_busy <= 1'b1;
          rx_cnt  <= 16'(BIT_CYCLES / 2);
          rx_bit  <= '0;
        end
      end else if (rx_cnt != 0) begin
        rx_cnt <= rx_cnt - 1'b1;
      end else begin
        rx_cnt <= 16'(BIT_CYCLES - 1);
        rx_bit <= rx_bit + 1'b1;
        if (rx_bit == 4'd0 && rx_sync[1]) begin
          rx_busy <= 1'b0; // False start
        end else if (rx_bit >= 4'd1 && rx_bit <= 4'd8) begin
          rx_sh <= {rx_sync[1], rx_sh[7:1]};
        end else if (rx_bit == 4'd9) begin
          rx_busy <= 1'b0;
          rx_stb  <= rx_sync[1]; // Framing error drops the byte
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // CRC helper, reflected 16-bit
  // ---------------------------------------------------------------
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction : crc_step

  // ---------------------------------------------------------------
  // Packet collector
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_RECV  = 4'b0010,
    ST_REPLY = 4'b0100,
    ST_EXEC  = 4'b1000
  } spch_state_e;
  spch_state_e state;
  logic [7:0]  rx_cnt_b;
  logic [7:0]  hdr_len;
  logic [7:0]  hdr_cmd;
  logic [7:0]  setup_b [4];
  logic [15:0] crc_run;
  logic [15:0] crc_prev;
  logic [7:0]  last_b;
  logic [7:0]  prev_b;
  logic        bad_pre;
  logic        fifo_in_ready;
  logic        fifo_valid;
  wire         is_payload = rx_stb && state == ST_RECV && hdr_cmd == CMD_SEND && rx_cnt_b >= 8'd3;
  always_ff @(posedge core_clk_i) begin
    if (srst_i || state == ST_IDLE) begin
      rx_cnt_b <= '0; hdr_len <= '0; hdr_cmd <= '0; crc_run <= CRC_INIT; crc_prev <= CRC_INIT;
      last_b <= '0; prev_b <= '0; bad_pre <= 1'b0;
      for (int i = 0; i < 4; i++) setup_b[i] <= '0;
    end else if (rx_stb && state == ST_RECV) begin
      rx_cnt_b <= (rx_cnt_b == 8'hff) ? rx_cnt_b : rx_cnt_b + 1'b1;
      prev_b   <= last_b;
      last_b   <= rx_sh;
      crc_prev <= crc_run;
      crc_run  <= crc_step(crc_run, rx_sh);
      if (rx_cnt_b == 8'd0 && rx_sh != PREAMBLE) bad_pre <= 1'b1;
      if (rx_cnt_b == 8'd1) hdr_len <= rx_sh;
      if (rx_cnt_b == 8'd2) hdr_cmd <= rx_sh;
      if (rx_cnt_b >= 8'(SETUP_CHAN) && rx_cnt_b <= 8'(SETUP_IMAX)) begin
        setup_b[rx_cnt_b[1:0] - 2'd3] <= rx_sh;
      end
    end
  end

  // Packet check at the end of frame
  logic [15:0] crc_data;
  always_ff @(posedge core_clk_i) begin
    if (srst_i) crc_data <= CRC_INIT;
    else if (rx_stb && state == ST_RECV) crc_data <= crc_prev;
  end
  wire crc_ok  = {last_b, prev_b} == (crc_data ^ CRC_XOROUT);
  wire len_ok  = hdr_len == rx_cnt_b && rx_cnt_b >= LEN_SHORT;
  wire cmd_ok  = (hdr_cmd == CMD_SEND && hdr_len >= LEN_SEND_MIN && hdr_len <= LEN_SEND_MAX)
              || (hdr_cmd == CMD_SETUP && hdr_len == LEN_SETUP
                  && setup_b[0] <= CHAN_MAX
                  && setup_b[1] >= BURST_MIN && setup_b[1] <= BURST_MAX
                  && setup_b[2] >= IMIN_MIN && setup_b[2] <= IMIN_MAX
                  && setup_b[3] >= IMAX_MIN && setup_b[3] <= IMAX_MAX)
              || ((hdr_cmd == CMD_SERIAL || hdr_cmd == CMD_ABORT || hdr_cmd == CMD_BURSTS
                   || hdr_cmd == CMD_FWVER) && hdr_len == LEN_SHORT);
  wire pkt_ok  = !bad_pre && len_ok && crc_ok && cmd_ok;

  // ---------------------------------------------------------------
  // Reply builder and transmitter
  // ---------------------------------------------------------------
  logic [7:0]  rp_buf [9];
  logic [7:0]  rp_len;
  logic [7:0]  rp_idx;
  logic [15:0] rp_crc;
  logic        ok_lat;
  logic [15:0] tx_cnt;
  logic [3:0]  tx_bit;
  logic [9:0]  tx_sh;
  logic        tx_busy;
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      state <= ST_IDLE; ok_lat <= 1'b0; rp_len <= '0; rp_idx <= '0; rp_crc <= CRC_INIT;
      tx_cnt <= '0; tx_bit <= '0; tx_sh <= '1; tx_busy <= 1'b0; tx_o <= 1'b1;
      for (int i = 0; i < 9; i++) rp_buf[i] <= '0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (rts_act) state <= ST_RECV;
        end
        ST_RECV: begin
          if (rts_fall && !rx_busy) begin
            state  <= ST_REPLY;
            ok_lat <= pkt_ok;
            rp_idx <= '0;
            rp_crc <= CRC_INIT;
            rp_buf[0] <= PREAMBLE;
            rp_buf[2] <= pkt_ok ? hdr_cmd : NAK_CMD;
            rp_len    <= LEN_SHORT;
            rp_buf[1] <= LEN_SHORT;
            if (pkt_ok && hdr_cmd == CMD_SERIAL) begin
              rp_len <= LEN_SERIAL; rp_buf[1] <= LEN_SERIAL;
              rp_buf[3] <= UNIT_SERIAL[31:24]; rp_buf[4] <= UNIT_SERIAL[23:16];
              rp_buf[5] <= UNIT_SERIAL[15:8];  rp_buf[6] <= UNIT_SERIAL[7:0];
            end else if (pkt_ok && hdr_cmd == CMD_BURSTS) begin
              rp_len <= LEN_BURSTS; rp_buf[1] <= LEN_BURSTS; rp_buf[3] <= bursts_left_i;
            end else if (pkt_ok && hdr_cmd == CMD_FWVER) begin
              rp_len <= LEN_FWVER; rp_buf[1] <= LEN_FWVER;
              rp_buf[3] <= FW_MAJOR; rp_buf[4] <= FW_MINOR;
            end
          end
        end
        ST_REPLY: begin
          if (!tx_busy) begin
            if (rp_idx == rp_len) begin
              state <= ST_EXEC;
            end else begin
              logic [7:0] b;
              b = (rp_idx == rp_len - 8'd2) ? rp_crc[7:0] ^ CRC_XOROUT[7:0] :
                  (rp_idx == rp_len - 8'd1) ? rp_crc[15:8] ^ CRC_XOROUT[15:8] : rp_buf[rp_idx[3:0]];
              if (rp_idx < rp_len - 8'd2) rp_crc <= crc_step(rp_crc, b);
              tx_sh   <= {1'b1, b, 1'b0};
              tx_busy <= 1'b1;
              tx_bit  <= '0;
              tx_cnt  <= 16'(BIT_CYCLES - 1);
              rp_idx  <= rp_idx + 1'b1;
            end
          end
        end
        ST_EXEC: begin
          state <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
      if (tx_busy) begin
        tx_o <= tx_sh[0];
        if (tx_cnt != 0) begin
          tx_cnt <= tx_cnt - 1'b1;
        end else begin
          tx_cnt <= 16'(BIT_CYCLES - 1);
          tx_sh  <= {1'b1, tx_sh[9:1]};
          tx_bit <= tx_bit + 1'b1;
          if (tx_bit == 4'd9) tx_busy <= 1'b0;
        end
      end else begin
        tx_o <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Payload FIFO, released only after the reply
  // ---------------------------------------------------------------
  logic       pay_hold;
  logic [7:0] fifo_data;
  logic       fifo_pop;
  wire        fifo_push = is_payload && rx_cnt_b < hdr_len - 8'd2;
  spch_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .core_clk_i  (core_clk_i),
    .srst_i      (srst_i || (state == ST_EXEC && !ok_lat)),
    .in_data_i   (rx_sh),
    .in_valid_i  (fifo_push),
    .in_ready_o  (fifo_in_ready),
    .out_data_o  (fifo_data),
    .out_valid_o (fifo_valid),
    .out_ready_i (fifo_pop)
  );
  // CRC bytes are kept out of the queue by count
  assign fifo_pop = pay_hold && fifo_valid && (!pay_valid_o || pay_ready_i);
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      pay_hold <= 1'b0; pay_valid_o <= 1'b0; pay_data_o <= '0; send_start_o <= 1'b0; abort_o <= 1'b0;
      setup_store_o <= 1'b0; rf_channel_o <= RST_CHAN; burst_count_o <= RST_BURST;
      interval_min_o <= RST_IMIN; interval_max_o <= RST_IMAX;
    end else begin
      send_start_o  <= 1'b0;
      abort_o       <= 1'b0;
      setup_store_o <= 1'b0;
      if (state == ST_EXEC && ok_lat) begin
        case (hdr_cmd)
          CMD_SEND:  begin pay_hold <= 1'b1; send_start_o <= 1'b1; end
          CMD_ABORT: abort_o <= 1'b1;
          CMD_SETUP: begin
            rf_channel_o   <= setup_b[0][1:0];
            burst_count_o  <= setup_b[1];
            interval_min_o <= setup_b[2];
            interval_max_o <= setup_b[3];
            setup_store_o  <= 1'b1;
          end
          default: ;
        endcase
      end
      if (!fifo_valid && (!pay_valid_o || pay_ready_i)) pay_hold <= 1'b0;
      if (fifo_pop) begin
        pay_valid_o <= 1'b1;
        pay_data_o  <= fifo_data;
      end else if (pay_ready_i) begin
        pay_valid_o <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Power state
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      awake_o <= 1'b0; sleep_o <= 1'b1;
    end else begin
      awake_o <= rts_act || state != ST_IDLE;
      sleep_o <= !rts_act && state == ST_IDLE && !tx_busy_i && !pay_hold && !rx_busy;
    end
  end
endmodule : spch_handler
`default_nettype wire

//--- inc/spch_pkg.sv
// Package of constants for the serial packet command handler
`default_nettype none
package spch_pkg;
  localparam int          CLK_HZ        = 20000000;
  localparam int          BAUD          = 9600;
  localparam int          BIT_CYC       = CLK_HZ / BAUD;
  localparam int          HALF_CYC      = BIT_CYC / 2;
  localparam logic [7:0]  PREAMBLE      = 8'haa;
  localparam logic [7:0]  NAK_CMD       = 8'hff;
  localparam logic [7:0]  CMD_SEND      = 8'h00;
  localparam logic [7:0]  CMD_SERIAL    = 8'h01;
  localparam logic [7:0]  CMD_ABORT     = 8'h03;
  localparam logic [7:0]  CMD_BURSTS    = 8'h04;
  localparam logic [7:0]  CMD_FWVER     = 8'h05;
  localparam logic [7:0]  CMD_SETUP     = 8'h06;
  localparam logic [7:0]  LEN_SHORT     = 8'h05;
  localparam logic [7:0]  LEN_SERIAL    = 8'h09;
  localparam logic [7:0]  LEN_BURSTS    = 8'h06;
  localparam logic [7:0]  LEN_FWVER     = 8'h07;
  localparam logic [7:0]  LEN_SETUP     = 8'h0e;
  localparam logic [7:0]  LEN_SEND_MIN  = 8'h06;
  localparam logic [7:0]  LEN_SEND_MAX  = 8'h95;
  localparam logic [7:0]  CHAN_MAX      = 8'h03;
  localparam logic [7:0]  BURST_MIN     = 8'h01;
  localparam logic [7:0]  BURST_MAX     = 8'h14;
  localparam logic [7:0]  IMIN_MIN      = 8'h01;
  localparam logic [7:0]  IMIN_MAX      = 8'h3c;
  localparam logic [7:0]  IMAX_MIN      = 8'h02;
  localparam logic [7:0]  IMAX_MAX      = 8'h78;
  localparam int          SETUP_CHAN    = 7;
  localparam int          SETUP_BURST   = 8;
  localparam int          SETUP_IMIN    = 9;
  localparam int          SETUP_IMAX    = 10;
  localparam logic [15:0] CRC_INIT      = 16'hffff;
  localparam logic [15:0] CRC_POLY      = 16'h8408;
  localparam logic [15:0] CRC_XOROUT    = 16'hffff;
  localparam logic [1:0]  RST_CHAN      = 2'h0;
  localparam logic [7:0]  RST_BURST     = 8'h03;
  localparam logic [7:0]  RST_IMIN      = 8'h18;
  localparam logic [7:0]  RST_IMAX      = 8'h30;
endpackage : spch_pkg
`default_nettype wire

//--- verilog/spch_fifo.sv
// Synchronous valid/ready FIFO for payload bytes
`default_nettype none
module spch_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             core_clk_i,
  input  wire logic             srst_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  output logic [WIDTH-1:0]      out_data_o,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) $error("spch_fifo: bad WIDTH or DEPTH");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  logic             push;
  logic             pop;
  assign in_ready_o  = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
  assign out_valid_o = wr_ptr != rd_ptr;
  assign out_data_o  = mem[rd_ptr[AW-1:0]];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;
  always_ff @(posedge core_clk_i) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data_i;
    end
  end
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end
endmodule : spch_fifo
`default_nettype wire

//--- testbench/spch_handler_properties.sv
// Concurrent checks on the packet handler ports
`default_nettype none
module spch_handler_props
  import spch_pkg::*;
#(
  parameter int FIFO_DEPTH = 16
) (
  input wire logic       core_clk_i,
  input wire logic       srst_i,
  input wire logic       rx_i,
  input wire logic       rts_n_i,
  input wire logic       tx_o,
  input wire logic       awake_o,
  input wire logic       sleep_o,
  input wire logic [7:0] pay_data_o,
  input wire logic       pay_valid_o,
  input wire logic       pay_ready_i,
  input wire logic       send_start_o,
  input wire logic       abort_o,
  input wire logic       tx_busy_i,
  input wire logic [7:0] bursts_left_i,
  input wire logic [1:0] rf_channel_o,
  input wire logic [7:0] burst_count_o,
  input wire logic [7:0] interval_min_o,
  input wire logic [7:0] interval_max_o,
  input wire logic       setup_store_o
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (srst_i);
  // ----------------------------------------
  // Sequences
  // ----------------------------------------
  // Four cycles covers the two-flop sync plus the output register
  sequence s_frame_held;
    !rts_n_i [*4];
  endsequence
  sequence s_line_idle;
    tx_o ##1 tx_o;
  endsequence
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  a_reset_outputs: assert property (disable iff (1'b0) srst_i |=> tx_o && sleep_o && !awake_o
    && rf_channel_o == RST_CHAN && burst_count_o == RST_BURST && interval_max_o == RST_IMAX)
    else $error("outputs not at reset values");
  a_quiet_while_framed: assert property (s_frame_held |-> tx_o)
    else $error("device transmits while host frames");
  a_wake_on_rts: assert property (s_frame_held |-> awake_o && !sleep_o)
    else $error("device asleep during frame");
  a_busy_blocks_sleep: assert property (tx_busy_i [*2] |-> !sleep_o)
    else $error("sleep while transmission pending");
  a_action_after_reply: assert property ((abort_o || send_start_o) |-> s_line_idle)
    else $error("action pulse while reply on line");
  a_start_single: assert property (send_start_o |=> !send_start_o)
    else $error("start pulse longer than one cycle");
  a_abort_single: assert property (abort_o |=> !abort_o)
    else $error("abort pulse longer than one cycle");
  a_burst_range: assert property (burst_count_o inside {[BURST_MIN:BURST_MAX]})
    else $error("burst count out of range");
  a_imin_range: assert property (interval_min_o inside {[IMIN_MIN:IMIN_MAX]})
    else $error("minimum interval out of range");
  a_imax_range: assert property (interval_max_o inside {[IMAX_MIN:IMAX_MAX]})
    else $error("maximum interval out of range");
  a_pay_hold: assert property (pay_valid_o && !pay_ready_i |=> pay_valid_o && $stable(pay_data_o))
    else $error("payload dropped while stalled");
endmodule : spch_handler_props
bind spch_handler spch_handler_props #(.FIFO_DEPTH(FIFO_DEPTH)) u_props (
  .core_clk_i(core_clk_i), .srst_i(srst_i), .rx_i(rx_i), .rts_n_i(rts_n_i), .tx_o(tx_o),
  .awake_o(awake_o), .sleep_o(sleep_o), .pay_data_o(pay_data_o), .pay_valid_o(pay_valid_o),
  .pay_ready_i(pay_ready_i), .send_start_o(send_start_o), .abort_o(abort_o), .tx_busy_i(tx_busy_i),
  .bursts_left_i(bursts_left_i), .rf_channel_o(rf_channel_o), .burst_count_o(burst_count_o),
  .interval_min_o(interval_min_o), .interval_max_o(interval_max_o), .setup_store_o(setup_store_o));
`default_nettype wire

//--- testbench/spch_host_model.sv
// Host terminal model: frames command packets with RTS and reads replies
`default_nettype none
module spch_host_model
  import spch_pkg::*;
#(
  parameter int BIT_CYCLES = BIT_CYC
) (
  input  wire logic core_clk_i,
  input  wire logic dev_tx_i,
  output var logic  rx_o,
  output var logic  rts_n_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // Idle levels of the pulled-up pins
  initial begin
    rx_o    = 1'b1;
    rts_n_o = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask : tick
  task automatic put_byte(input logic [7:0] b);
    logic [9:0] frame;
    frame = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rx_o = frame[i];
      tick(BIT_CYCLES);
    end
  endtask : put_byte
  // Bytes go out in list order, so CRC low byte precedes high byte
  task automatic send_packet(input logic [7:0] pkt[$]);
    tick(1);
    rts_n_o = 1'b0;
    tick(BIT_CYCLES);
    foreach (pkt[i]) put_byte(pkt[i]);
    rts_n_o = 1'b1;
  endtask : send_packet
  // Listens only after the frame is released: half duplex
  task automatic get_byte(output logic [7:0] b, output logic ok);
    int n;
    n = 0;
    b = 8'h00;
    while (dev_tx_i !== 1'b0 && n < 40 * BIT_CYCLES) begin
      @(posedge core_clk_i);
      n++;
    end
    repeat (BIT_CYCLES / 2) @(posedge core_clk_i);
    ok = (n < 40 * BIT_CYCLES) && (dev_tx_i === 1'b0);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CYCLES) @(posedge core_clk_i);
      b[i] = dev_tx_i;
    end
    repeat (BIT_CYCLES) @(posedge core_clk_i);
    ok = ok && (dev_tx_i === 1'b1);
  endtask : get_byte
endmodule : spch_host_model
`default_nettype wire

//--- testbench/spch_handler_tb_top.sv
// Self-checking bench for the packet handler
`default_nettype none
module spch_handler_tb_top
  import spch_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int          TB_BIT    = 20;            // Short bit time keeps the run brief
  localparam logic [31:0] TB_SERIAL = 32'h1234_5678; // Arbitrary value
  logic       core_clk_i, srst_i, rx, rts_n, tx, awake, sleep, pay_valid, pay_ready_i;
  logic       send_start, abort, tx_busy_i, setup_store;
  logic [7:0] pay_data, bursts_left_i, burst_count, imin, imax;
  logic [1:0] rf_channel;
  logic [7:0] pay_got[$];
  int         bad_count, compares, abort_seen, start_seen, store_seen;
  spch_handler #(.UNIT_SERIAL(TB_SERIAL), .FW_MAJOR(8'h02), .FW_MINOR(8'h09), .BIT_CYCLES(TB_BIT)) DUT (
    .core_clk_i(core_clk_i), .srst_i(srst_i), .rx_i(rx), .rts_n_i(rts_n), .tx_o(tx), .awake_o(awake),
    .sleep_o(sleep), .pay_data_o(pay_data), .pay_valid_o(pay_valid), .pay_ready_i(pay_ready_i),
    .send_start_o(send_start), .abort_o(abort), .tx_busy_i(tx_busy_i), .bursts_left_i(bursts_left_i),
    .rf_channel_o(rf_channel), .burst_count_o(burst_count), .interval_min_o(imin),
    .interval_max_o(imax), .setup_store_o(setup_store));
  spch_host_model #(.BIT_CYCLES(TB_BIT)) host (.core_clk_i(core_clk_i), .dev_tx_i(tx), .rx_o(rx), .rts_n_o(rts_n));
  initial begin
    core_clk_i = 1'b0;
    forever #25 core_clk_i = ~core_clk_i;
  end
  // Sink stalls every other cycle to exercise the payload queue
  always @(posedge core_clk_i) begin
    if (abort === 1'b1) abort_seen++;
    if (send_start === 1'b1) start_seen++;
    if (setup_store === 1'b1) store_seen++;
    if (pay_valid === 1'b1 && pay_ready_i === 1'b1) pay_got.push_back(pay_data);
    #1 pay_ready_i = ~pay_ready_i;
  end
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_of_test
  task automatic exchange(input logic [7:0] cmd[$], input logic [7:0] exp[$]);
    logic [7:0] b;
    logic       ok;
    int         acts;
    acts = abort_seen + start_seen;
    host.send_packet(cmd);
    check("awake", 8'(awake), 8'h01);
    foreach (exp[i]) begin
      host.get_byte(b, ok);
      check("framing", 8'(ok), 8'h01);
      check("reply byte", b, exp[i]);
      if (i == exp.size() - 2) check("early action", 8'(abort_seen + start_seen - acts), 8'h00);
    end
    repeat (TB_BIT / 2 + 64) @(posedge core_clk_i);
    #1;
  endtask : exchange
  function automatic logic [15:0] crc_of(input logic [7:0] p[$]);
    logic [15:0] r;
    r = CRC_INIT;
    foreach (p[i]) begin
      r = r ^ {8'h00, p[i]};
      for (int k = 0; k < 8; k++) begin
        r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
      end
    end
    return r ^ CRC_XOROUT;
  endfunction : crc_of
  // Check bytes appended low byte first to request and expected reply
  task automatic exchange_crc(input logic [7:0] cmd[$], input logic [7:0] exp[$]);
    logic [15:0] c;
    logic [15:0] e;
    c = crc_of(cmd);
    e = crc_of(exp);
    cmd.push_back(c[7:0]);
    cmd.push_back(c[15:8]);
    exp.push_back(e[7:0]);
    exp.push_back(e[15:8]);
    exchange(cmd, exp);
  endtask : exchange_crc
  task automatic test_query();
    exchange_crc('{8'haa, 8'h05, 8'h01}, '{8'haa, 8'h09, 8'h01, 8'h12, 8'h34, 8'h56, 8'h78});
    exchange_crc('{8'haa, 8'h05, 8'h04}, '{8'haa, 8'h06, 8'h04, 8'h02});
    exchange_crc('{8'haa, 8'h05, 8'h05}, '{8'haa, 8'h07, 8'h05, 8'h02, 8'h09});
    $display("test query done");
  endtask : test_query
  task automatic test_setup();
    exchange_crc('{8'haa, 8'h0e, 8'h06, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h05, 8'h10, 8'h20, 8'h00},
                 '{8'haa, 8'h05, 8'h06});
    check("store pulses", 8'(store_seen), 8'h01);
    check("channel set", 8'(rf_channel), 8'h02);
    check("bursts set", burst_count, 8'h05);
    check("imin set", imin, 8'h10);
    check("imax set", imax, 8'h20);
    // Twenty-one bursts is out of range: refused, settings kept
    exchange_crc('{8'haa, 8'h0e, 8'h06, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h15, 8'h10, 8'h20, 8'h00},
                 '{8'haa, 8'h05, 8'hff});
    check("store refused", 8'(store_seen), 8'h01);
    check("bursts kept", burst_count, 8'h05);
    check("channel kept", 8'(rf_channel), 8'h02);
    $display("test setup done");
  endtask : test_setup
  task automatic test_reset();
    check("tx idle", 8'(tx), 8'h01);
    check("sleep", 8'(sleep), 8'h01);
    check("channel", 8'(rf_channel), 8'(RST_CHAN));
    check("bursts", burst_count, RST_BURST);
    check("imin", imin, RST_IMIN);
    check("imax", imax, RST_IMAX);
    $display("test reset done");
  endtask : test_reset
  task automatic test_send();
    exchange('{8'haa, 8'h0e, 8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09,
               8'hbe, 8'he8}, '{8'haa, 8'h05, 8'h00, 8'hd9, 8'hc4});
    check("start pulses", 8'(start_seen), 8'h01);
    check("payload count", 8'(pay_got.size()), 8'h09);
    foreach (pay_got[i]) check("payload", pay_got[i], 8'(i + 1));
    $display("test send done");
  endtask : test_send
  task automatic test_abort();
    exchange('{8'haa, 8'h05, 8'h03, 8'h42, 8'hf6}, '{8'haa, 8'h05, 8'h03, 8'h42, 8'hf6});
    check("abort pulses", 8'(abort_seen), 8'h01);
    $display("test abort done");
  endtask : test_abort
  // Corrupted CRC must be refused with no action taken
  task automatic test_nak();
    exchange('{8'haa, 8'h05, 8'h03, 8'h42, 8'hf7}, '{8'haa, 8'h05, 8'hff, 8'ha1, 8'hcb});
    check("no action", 8'(abort_seen + start_seen), 8'h02);
    $display("test nak done");
  endtask : test_nak
  task automatic test_sleep();
    check("idle sleep", 8'(sleep), 8'h01);
    tx_busy_i = 1'b1;
    repeat (4) @(posedge core_clk_i);
    #1;
    check("busy sleep", 8'(sleep), 8'h00);
    tx_busy_i = 1'b0;
    repeat (2) @(posedge core_clk_i);
    #1;
    check("wake sleep", 8'(sleep), 8'h01);
    $display("test sleep done");
  endtask : test_sleep
  initial begin
    srst_i        = 1'b1;
    tx_busy_i     = 1'b0;
    pay_ready_i   = 1'b1;
    bursts_left_i = 8'h02;
    repeat (4) @(posedge core_clk_i);
    #1 srst_i = 1'b0;
    repeat (2) @(posedge core_clk_i);
    #1;
    test_reset();
    test_send();
    test_abort();
    test_nak();
    test_query();
    test_setup();
    test_sleep();
    end_of_test();
  end
  // About 120 characters of 200 cycles each, with the limit at two and a half times that
  initial begin
    repeat (60000) @(posedge core_clk_i);
    bad_count++;
    $display("watchdog expired");
    end_of_test();
  end
endmodule : spch_handler_tb_top
`default_nettype wire
